/* rtl/sbh_arbiter.sv */
// arbiter lending the server unit's i2c bus to an external controller
`timescale 1ns/100ps

// ****************************************
// shared i2c bus handoff
// ****************************************
module sbh_arbiter import sbh_pkg::*; #(
  parameter int GP_PINS = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // handshake with external controller
  input wire logic bus_request,
  output logic bus_grant,
  // idle point of the server unit's own work
  input wire logic unit_idle,
  // input values for the snapshot, and the general purpose pins passed to gp_pins
  input wire sbh_snap_t snap_in,
  input wire logic [GP_PINS-1:0] gp_pins_in,
  // shared memory port of the server unit (bus of the memory side)
  output logic shm_we,
  output logic [5:0] shm_addr,
  output logic [7:0] shm_wdata,
  input wire logic [7:0] shm_rdata,
  // i2c driver enables, low while driving
  output logic scl_oe_n,
  output logic sda_oe_n,
  // applied controls
  output sbh_ctrl_t ctrl_out,
  output logic ctrl_changed,
  output logic lcd_update,
  output logic [7:0] lcd_cmd,
  output logic web_pause,
  output logic [GP_PINS-1:0] gp_pins
);

  // refuse pin counts that the snapshot byte cannot carry
  if (GP_PINS < 1 || GP_PINS > 8) begin : g_bad_pins
    $error("GP_PINS must be 1 to 8");
  end

  // ****************************************
  // synchronisers
  // ****************************************
  logic req_meta, req_sync;
  logic [GP_PINS-1:0] gp_meta, gp_sync;

  always_ff @(posedge mclk) begin
    if (rst) begin
      req_meta <= 1'b0;
      req_sync <= 1'b0;
      gp_meta <= '0;
      gp_sync <= '0;
    end else begin
      req_meta <= bus_request;
      req_sync <= req_meta;
      gp_meta <= gp_pins_in;
      gp_sync <= gp_meta;
    end
  end

  // ****************************************
  // handoff state machine
  // ****************************************
  sbh_state_t state, next_state;
  logic [2:0] idx, next_idx;
  logic rd_pend, next_rd_pend;
  sbh_ctrl_t ctrl, next_ctrl, stage, next_stage;
  logic grant, next_grant;
  logic we, next_we;
  logic [5:0] addr, next_addr;
  logic [7:0] wdata, next_wdata;
  logic drv_off, next_drv_off;
  logic changed, next_changed;
  logic lcd_go, next_lcd_go;
  logic [7:0] lcd_val, next_lcd_val;
  logic pause, next_pause;
  logic [63:0] snap_bits;

  assign snap_bits = snap_in;

  always_comb begin
    next_state = state;
    next_idx = idx;
    next_rd_pend = 1'b0;
    next_ctrl = ctrl;
    next_stage = stage;
    next_grant = grant;
    next_we = 1'b0;
    next_addr = addr;
    next_wdata = wdata;
    next_drv_off = drv_off;
    next_changed = 1'b0;
    next_lcd_go = 1'b0;
    next_lcd_val = lcd_val;
    next_pause = pause;
    case (state)
      SBH_IDLE: begin
        next_drv_off = 1'b0;
        if (req_sync && unit_idle) begin
          next_state = SBH_SNAP;
          next_idx = 3'h0;
          next_pause = 1'b1;
        end
      end
      SBH_SNAP: begin
        // one snapshot byte per cycle into bytes 8..15
        next_we = 1'b1;
        next_addr = SNAP_FIRST + {3'h0, idx};
        next_wdata = snap_bits[idx*8 +: 8];
        next_idx = idx + 3'h1;
        if (idx == 3'h7) begin
          next_state = SBH_GRANT;
          next_drv_off = 1'b1;
        end
      end
      SBH_GRANT: begin
        next_drv_off = 1'b1;
        // grant only after drivers have been released
        if (drv_off && !we && req_sync) next_grant = 1'b1;
        if (grant && !req_sync) begin
          next_grant = 1'b0;
          next_state = SBH_APPLY;
          next_idx = 3'h0;
          next_addr = CTRL_FIRST;
          next_rd_pend = 1'b1;
        end else if (!grant && !req_sync && drv_off && !we) begin
          next_state = SBH_APPLY; // request withdrawn before grant
          next_idx = 3'h0;
          next_addr = CTRL_FIRST;
          next_rd_pend = 1'b1;
        end
      end
      SBH_APPLY: begin
        // drivers stay off until all eight control bytes have been read back
        next_drv_off = 1'b1;
        if (rd_pend) begin
          next_stage[idx*8 +: 8] = shm_rdata;
          if (idx == 3'h7) begin
            next_state = SBH_IDLE;
            next_pause = 1'b0;
            if (next_stage != ctrl) next_changed = 1'b1;
            next_ctrl = next_stage;
            if (next_stage.lcd_copy != BYTE_RESET) begin
              next_lcd_go = 1'b1;
              next_lcd_val = next_stage.lcd_copy;
            end
          end else begin
            next_idx = idx + 3'h1;
            next_addr = CTRL_FIRST + {3'h0, idx + 3'h1};
            next_rd_pend = 1'b1;
          end
        end
      end
      default: next_state = SBH_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= SBH_IDLE;
      idx <= 3'h0;
      rd_pend <= 1'b0;
      ctrl <= '{pin_direction_mask: DIR_RESET, default: BYTE_RESET};
      stage <= '0;
      grant <= 1'b0;
      we <= 1'b0;
      addr <= 6'h00;
      wdata <= BYTE_RESET;
      drv_off <= 1'b0;
      changed <= 1'b0;
      lcd_go <= 1'b0;
      lcd_val <= BYTE_RESET;
      pause <= 1'b0;
      gp_pins <= '0;
    end else begin
      state <= next_state;
      idx <= next_idx;
      rd_pend <= next_rd_pend;
      ctrl <= next_ctrl;
      stage <= next_stage;
      grant <= next_grant;
      we <= next_we;
      addr <= next_addr;
      wdata <= next_wdata;
      drv_off <= next_drv_off;
      changed <= next_changed;
      lcd_go <= next_lcd_go;
      lcd_val <= next_lcd_val;
      pause <= next_pause;
      gp_pins <= gp_sync;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign bus_grant = grant;
  assign shm_we = we;
  assign shm_addr = addr;
  assign shm_wdata = wdata;
  // enables are high exactly while the drivers are released
  assign scl_oe_n = drv_off;
  assign sda_oe_n = drv_off;
  assign ctrl_out = ctrl;
  assign ctrl_changed = changed;
  assign lcd_update = lcd_go;
  assign lcd_cmd = lcd_val;
  assign web_pause = pause;

endmodule

/* rtl/sbh_pkg.sv */
// package for the shared i2c bus handoff arbiter
package sbh_pkg;
  // shared memory layout
  localparam int SHM_DEPTH = 64;
  localparam logic [5:0] SNAP_FIRST = 6'h08;
  localparam logic [5:0] SNAP_LAST = 6'h0f;
  localparam logic [5:0] CTRL_FIRST = 6'h10;
  localparam logic [5:0] CTRL_LAST = 6'h17;
  localparam logic [5:0] LCD_CMD_ADDR = 6'h16;
  localparam logic [5:0] BURST_EXAMPLE_ADDR = 6'h32;
  localparam logic [6:0] SHM_SLAVE_ADDR = 7'h68;
  // reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'hff;
  // i2c standard speed: 100 kHz bit rate
  localparam int CLK_HZ = 25000000;
  localparam int SCL_HZ = 100000;
  localparam int SCL_QUARTER = CLK_HZ / (SCL_HZ * 4);

  typedef enum logic [1:0] {SBH_IDLE, SBH_SNAP, SBH_GRANT, SBH_APPLY} sbh_state_t;

  // snapshot of inputs written to bytes 8..15
  typedef struct packed {
    logic [7:0] temp_frac;
    logic [7:0] temp_whole;
    logic [7:0] adc_low_bits;
    logic [7:0] adc3;
    logic [7:0] adc2;
    logic [7:0] adc1;
    logic [7:0] adc0;
    logic [7:0] input_port;
  } sbh_snap_t;

  // controls taken from bytes 16..23
  typedef struct packed {
    logic [7:0] reserved;
    logic [7:0] lcd_copy;
    logic [7:0] pwm_duty_hi;
    logic [7:0] pwm_duty_lo;
    logic [7:0] pwm_period;
    logic [7:0] special_function_select;
    logic [7:0] pin_direction_mask;
    logic [7:0] output_port;
  } sbh_ctrl_t;
endpackage

/* verif/sbh_arbiter_assertions.sv */
// checker for the bus handoff arbiter
`timescale 1ns/100ps
module sbh_arbiter_chk import sbh_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // handshake and memory port
  input wire logic bus_request,
  input wire logic bus_grant,
  input wire sbh_snap_t snap_in,
  input wire logic shm_we,
  input wire logic [5:0] shm_addr,
  input wire logic [7:0] shm_wdata,
  // drivers and status
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  input wire logic lcd_update,
  input wire logic [7:0] lcd_cmd,
  input wire logic web_pause
);
  // ****
  // handoff checks
  // ****
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_held;
    bus_grant && bus_request && $past(bus_request) && $past(bus_request, 2) && $past(bus_request, 3);
  endsequence
  sequence s_snap_done;
    shm_we && shm_addr == SNAP_LAST;
  endsequence
  AST_RELEASED: assert property (bus_grant |-> scl_oe_n && sda_oe_n)
    else $error("drivers active while granted");
  AST_EARLY_RELEASE: assert property ($rose(bus_grant) |-> $past(scl_oe_n))
    else $error("grant raised before release");
  AST_QUIET: assert property (bus_grant |-> !shm_we)
    else $error("memory write while granted");
  AST_HOLD: assert property (s_held |=> bus_grant)
    else $error("grant dropped under request");
  AST_PAUSE: assert property (bus_grant |-> web_pause)
    else $error("serving not paused");
  AST_SNAP: assert property (shm_we |-> shm_addr >= SNAP_FIRST
    && shm_addr <= SNAP_LAST && shm_wdata == snap_in[shm_addr[2:0]*8 +: 8])
    else $error("bad snapshot write");
  AST_GRANT_AFTER: assert property (s_snap_done ##0 bus_request |-> ##[1:6] bus_grant)
    else $error("grant late after snapshot");
  AST_DROP: assert property ($fell(bus_request) && bus_grant |-> ##[1:6] !bus_grant)
    else $error("grant not dropped");
  AST_RESUME: assert property ($fell(bus_grant) |-> scl_oe_n ##[1:40] !web_pause)
    else $error("no resume after return");
  AST_SYNC: assert property ($rose(web_pause) |-> $past(bus_request, 2))
    else $error("request used unsynchronised");
  AST_LCD: assert property (lcd_update |-> lcd_cmd != 8'h00 && $fell(web_pause))
    else $error("lcd update with zero command or before access ended");
endmodule
bind sbh_arbiter sbh_arbiter_chk chk (.mclk, .rst, .bus_request, .bus_grant, .snap_in,
  .shm_we, .shm_addr, .shm_wdata, .scl_oe_n, .sda_oe_n, .lcd_update, .lcd_cmd, .web_pause);

/* verif/sbh_ext_ctl.sv */
// external controller model with the shared memory
`timescale 1ns/100ps
module sbh_ext_ctl (
  // clock and handshake
  input wire logic mclk,
  input wire logic bus_grant,
  output logic bus_request,
  // shared memory port
  input wire logic shm_we,
  input wire logic [5:0] shm_addr,
  input wire logic [7:0] shm_wdata,
  output logic [7:0] shm_rdata
);
  // ****
  // controller and memory
  // ****
  logic [7:0] mem [64];
  logic lclk = 1'b0;
  initial bus_request = 1'b0;
  initial foreach (mem[i]) mem[i] = 8'h00;
  initial #7 forever #160 lclk = ~lclk;
  assign shm_rdata = mem[shm_addr];
  always @(posedge mclk) if (shm_we) mem[shm_addr] <= shm_wdata;
  // request and return move on the controller's own clock
  task automatic borrow(input logic [63:0] c, input int lat, output logic ok);
    int n;
    @(posedge lclk) bus_request <= 1'b1;
    for (n = 0; n < 400 && bus_grant !== 1'b1; n++) @(posedge mclk);
    ok = (n < 400);
    repeat (lat) @(posedge lclk);
    // subaddressed burst into bytes 16..23, never the eeprom
    for (n = 0; n < 8; n++) if (bus_grant === 1'b1) mem[16 + n] = c[8*n +: 8];
    @(posedge lclk) bus_request <= 1'b0;
  endtask
endmodule

/* verif/sbh_arbiter_tb.sv */
// testbench for the shared i2c bus handoff arbiter
`timescale 1ns/100ps
module sbh_arbiter_tb;
  import sbh_pkg::*;
  // ****
  // bench
  // ****
  logic mclk, rst, unit_idle, bus_request, bus_grant, shm_we, scl_oe_n, sda_oe_n;
  logic ctrl_changed, lcd_update, web_pause;
  logic [5:0] shm_addr;
  logic [7:0] shm_wdata, shm_rdata, lcd_cmd, gp_pins_in, gp_pins;
  logic [63:0] last = 64'h0000_0000_0000_ff00;
  sbh_snap_t snap_in;
  sbh_ctrl_t ctrl_out;
  int n_fail = 0, compares = 0, n_lcd = 0, n_chg = 0;
  sbh_arbiter dut (.mclk, .rst, .bus_request, .bus_grant, .unit_idle, .snap_in, .gp_pins_in,
    .shm_we, .shm_addr, .shm_wdata, .shm_rdata, .scl_oe_n, .sda_oe_n, .ctrl_out,
    .ctrl_changed, .lcd_update, .lcd_cmd, .web_pause, .gp_pins);
  sbh_ext_ctl p (.mclk, .bus_grant, .bus_request, .shm_we, .shm_addr, .shm_wdata, .shm_rdata);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (lcd_update === 1'b1) n_lcd <= n_lcd + 1;
    if (ctrl_changed === 1'b1) n_chg <= n_chg + 1;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one lending cycle, optionally while the unit is busy
  task automatic t_borrow(input logic [63:0] c, input int lat, input int busy);
    int n, l0, c0;
    logic ok;
    l0 = n_lcd;
    c0 = n_chg;
    unit_idle = (busy == 0);
    fork
      p.borrow(c, lat, ok);
      begin
        repeat (busy) @(negedge mclk);
        if (busy > 0) chk(bus_grant, 1'b0);
        unit_idle = 1'b1;
      end
    join
    chk(ok, 1'b1);
    for (n = 0; n < 100 && web_pause !== 1'b0; n++) @(negedge mclk);
    if (n == 100) begin
      n_fail++;
      report_and_stop();
    end
    repeat (2) @(negedge mclk);
    for (n = 0; n < 8; n++) chk(p.mem[8 + n], snap_in[8*n +: 8]);
    chk(ctrl_out, c);
    chk({scl_oe_n, sda_oe_n, bus_grant}, 3'b000);
    chk(64'(n_lcd - l0), c[55:48] != 8'h00);
    chk(64'(n_chg - c0), c !== last);
    if (c[55:48] != 8'h00) chk(lcd_cmd, c[55:48]);
    last = c;
  endtask
  initial begin
    rst = 1'b1;
    unit_idle = 1'b1;
    snap_in = 64'h0f0e_0d0c_0b0a_0908;
    gp_pins_in = 8'h00;
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    chk(ctrl_out, last);
    chk({bus_grant, web_pause, scl_oe_n}, 3'b000);
    gp_pins_in = 8'ha5;
    repeat (4) @(negedge mclk);
    chk(gp_pins, 8'ha5);
    t_borrow(64'h0081_2040_1003_f055, 3, 30);
    snap_in = 64'h6317_42c3_9a81_7e5c;
    t_borrow(64'h0000_2141_1104_0f5a, 0, 0);
    t_borrow(64'h0000_2141_1104_0f5a, 1, 0);
    report_and_stop();
  end
endmodule
